// ===== dv/ilfm_line_src.sv
// Partner model: bank of external switches driving the five input lines
`timescale 1ns/1ps
module ilfm_line_src (
  // Clock
  input wire logic clk_sys,
  // Requested switch levels
  input wire logic [4:0] want,
  // Input line pins
  output logic [4:0] lineIn
);
  // Contacts change only after an edge; levels are held until the next request
  always @(posedge clk_sys) begin
    lineIn <= want;
  end
endmodule

// ===== dv/ilfm_monitor.sv
// Checker of APB answers and run-state relations at the mapper top ports
`timescale 1ns/1ps
module ilfm_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Functions and run state
  input wire logic [3:0] speedSelect,
  input wire logic [2:0] remoteSetting,
  input wire logic outputRun,
  input wire logic decelStop,
  input wire logic coasting,
  input wire logic restartFromStart
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_acc; psel && penable && !pready; endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  property p_ans; s_acc |=> s_ans; endproperty
  property p_stray; pready |-> psel && penable; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  property p_remote; remoteSetting != 3'h0 |-> speedSelect[2:0] == 3'h0; endproperty
  property p_dec; decelStop |-> outputRun && !coasting; endproperty
  property p_coast; coasting |-> !outputRun && !decelStop; endproperty
  property p_start; $rose(outputRun) && !decelStop |-> restartFromStart; endproperty
  property p_pulse; restartFromStart |=> !restartFromStart; endproperty
  a_ans: assert property (p_ans) else $error("pready not one cycle after access");
  a_stray: assert property (p_stray) else $error("pready outside access");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_idle: assert property (p_idle) else $error("prdata not zero when idle");
  a_remote: assert property (p_remote) else $error("speed select in remote mode");
  a_dec: assert property (p_dec) else $error("decel state outputs wrong");
  a_coast: assert property (p_coast) else $error("coast state outputs wrong");
  a_start: assert property (p_start) else $error("run start without restart");
  a_pulse: assert property (p_pulse) else $error("restart pulse too long");
endmodule
bind ilfm_top ilfm_monitor mon_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .speedSelect(speedSelect), .remoteSetting(remoteSetting), .outputRun(outputRun),
  .decelStop(decelStop), .coasting(coasting), .restartFromStart(restartFromStart));

// ===== dv/testbench.sv
// Self-checking bench of the input line function mapper
`timescale 1ns/1ps
module testbench;
  import ilfm_pkg::*;
  localparam logic [15:0] CODES [22] = '{0, 1, 2, 3, 4, 5, 7, 8, 10, 12, 14, 16, 24, 25, 60,
    61, 62, 64, 65, 66, 67, 72};
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [4:0] want = 5'h0, lineIn;
  logic panelStop = 0, commErrStop = 0, preexciteCmd = 0, preexciteBusy = 0, motorStopped = 0;
  logic [FN_COUNT-1:0] funcActive;
  logic [3:0] speedSelect;
  logic [2:0] remoteSetting;
  logic outputRun, decelStop, coasting, restartFromStart;
  logic [15:0] startSpeed;
  int errors = 0, n_checks = 0, seed = 90, remote = 0, nStart = 0;
  int cfg [5] = '{60, 61, 0, 1, 2};
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (restartFromStart === 1'b1) nStart <= nStart + 1;
  ilfm_line_src src_u (.clk_sys(clk_sys), .want(want), .lineIn(lineIn));
  ilfm_top #(.FAST_CYC(4), .SLOW_CYC(8), .SEC_CYC(20)) dut_u (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lineIn(lineIn), .panelStop(panelStop), .commErrStop(commErrStop),
    .preexciteCmd(preexciteCmd), .preexciteBusy(preexciteBusy), .motorStopped(motorStopped),
    .funcActive(funcActive), .speedSelect(speedSelect), .remoteSetting(remoteSetting),
    .outputRun(outputRun), .decelStop(decelStop), .coasting(coasting),
    .restartFromStart(restartFromStart), .startSpeed(startSpeed));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask
  function automatic int idx(input int c);
    for (int i = 0; i < 22; i++) if (CODES[i] == c) return i;
    return -1;
  endfunction
  function automatic bit legal(input int ln, input int c);
    return c == 9999 || (idx(c) >= 0 && !(c == 60 && ln != 0) && !(c == 61 && ln != 1));
  endfunction
  function automatic logic [21:0] expf(input logic [4:0] lv);
    logic [21:0] f;
    f = '0;
    for (int i = 0; i < 5; i++) if (lv[i] && idx(cfg[i]) >= 0) f[idx(cfg[i])] = 1'b1;
    return f;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Request held until pready is seen; one idle edge keeps strobes from doubling
  task automatic apb(input logic w, input int a, input int d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a[7:0];
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input int a, input int d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk_bit(e, ee);
  endtask
  task automatic rd(input int a, input int d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 0, r, e);
    chk_bit(e, ee);
    if (!ee) chk_reg(r, d);
  endtask
  task automatic lines(input int a, input int b, input int c);
    cfg[2] = a;
    cfg[3] = b;
    cfg[4] = c;
    for (int i = 2; i < 5; i++) wr(i * 4, cfg[i], 1'b0);
  endtask
  // Filter plus sync and pipeline settle well inside 24 cycles at SLOW_CYC 8
  task automatic drv(input logic [4:0] lv);
    logic [21:0] f;
    want <= lv;
    repeat (24) @(posedge clk_sys);
    f = expf(lv);
    chk_reg({10'h0, funcActive}, {10'h0, f});
    chk_reg({28'h0, speedSelect}, {28'h0, f[7], f[2:0] & {3{remote == 0}}});
    chk_reg({29'h0, remoteSetting}, {29'h0, f[2:0] & {3{remote != 0}}});
  endtask
  task automatic st(input logic [2:0] e);
    chk_reg({29'h0, coasting, decelStop, outputRun}, {29'h0, e});
  endtask
  task automatic stopm;
    motorStopped <= 1'b1;
    repeat (4) @(posedge clk_sys);
    motorStopped <= 1'b0;
    @(posedge clk_sys);
    st(3'b000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int c, ln, sp, n0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) rd(i * 4, cfg[i], 1'b0);
    rd(8'h30, 0, 1'b1);
    repeat (40) begin
      ln = $unsigned($random(seed)) % 5;
      c = ($random(seed) & 1) ? CODES[$unsigned($random(seed)) % 22] : $unsigned($random(seed)) % 80;
      wr(ln * 4, c, !legal(ln, c));
      if (legal(ln, c)) cfg[ln] = c;
      rd(ln * 4, cfg[ln], 1'b0);
    end
    wr(4, 60, 1'b1);
    wr(0, 61, 1'b1);
    wr(8'h14, 1, 1'b0);
    wr(8, 3, 1'b1);
    rd(8, cfg[2], 1'b0);
    wr(8'h14, 0, 1'b0);
    wr(0, 60, 1'b0);
    wr(4, 61, 1'b0);
    cfg[0] = 60;
    cfg[1] = 61;
    lines(4, 7, 8);
    drv(5'b11100);
    lines(9999, 8, 9999);
    drv(5'b11100);
    repeat (6) begin
      lines(CODES[$unsigned($random(seed)) % 12], CODES[$unsigned($random(seed)) % 12],
        CODES[$unsigned($random(seed)) % 12]);
      drv({$random(seed)} % 32);
    end
    drv(5'b00000);
    stopm();
    remote = 1;
    wr(8'h18, 1, 1'b0);
    lines(0, 1, 2);
    drv(5'b11100);
    drv(5'b01000);
    remote = 0;
    wr(8'h18, 0, 1'b0);
    lines(10, 9999, 0);
    want <= 5'b11100;
    repeat (10) @(posedge clk_sys);
    chk_reg({10'h0, funcActive}, {10'h0, expf(5'b01100)});
    drv(5'b11100);
    lines(3, 3, 3);
    drv(5'b00000);
    n0 = nStart;
    drv(5'b00001);
    st(3'b001);
    chk_reg(nStart, n0 + 1);
    rd(8'h24, {10'h001, expf(5'b00001)}, 1'b0);
    rd(8'h28, 32'h0000_0101, 1'b0);
    drv(5'b00000);
    st(3'b011);
    stopm();
    sp = $unsigned($random(seed)) % 65536;
    wr(8'h20, sp, 1'b0);
    wr(8'h1c, 0, 1'b0);
    wr(8'h1c, 200, 1'b1);
    wr(8'h18, 32'h0001_0000, 1'b1);
    drv(5'b00001);
    drv(5'b00000);
    st(3'b100);
    n0 = nStart;
    drv(5'b00001);
    st(3'b001);
    chk_reg(nStart, n0 + 1);
    chk_reg({16'h0, startSpeed}, sp);
    wr(8'h1c, 5, 1'b0);
    for (int k = 0; k < 2; k++) begin
      {commErrStop, panelStop} <= 2'b01 << k;
      drv(5'b00000);
      st(3'b011);
      {commErrStop, panelStop} <= 2'b00;
      stopm();
      drv(5'b00001);
    end
    drv(5'b00000);
    st(3'b001);
    repeat (110) @(posedge clk_sys);
    st(3'b100);
    preexciteCmd <= 1'b1;
    preexciteBusy <= 1'b1;
    repeat (4) @(posedge clk_sys);
    st(3'b011);
    preexciteCmd <= 1'b0;
    preexciteBusy <= 1'b0;
    stopm();
    wr(8'h24, 0, 1'b1);
    results();
  end
endmodule

// ===== hw/ilfm_consts.svh
// Constants of the input line function mapper: offsets, reset values, codes, timing
`ifndef ILFM_CONSTS_SVH
`define ILFM_CONSTS_SVH

`define ILFM_NLINES 5
`define ILFM_CLK_MHZ 125
`define ILFM_FAST_RESP_US 2000
`define ILFM_SLOW_RESP_US 20000
`define ILFM_SEC_US 1000000
`define ILFM_PIPE_LAT 4
`define ILFM_FAST_CYC ((`ILFM_FAST_RESP_US * `ILFM_CLK_MHZ) - `ILFM_PIPE_LAT)
`define ILFM_SLOW_CYC ((`ILFM_SLOW_RESP_US * `ILFM_CLK_MHZ) - `ILFM_PIPE_LAT)
`define ILFM_SEC_CYC (`ILFM_SEC_US * `ILFM_CLK_MHZ)

`define ILFM_OFF_LINE0 8'h00
`define ILFM_OFF_EXTDISP 8'h14
`define ILFM_OFF_REMOTE 8'h18
`define ILFM_OFF_STOPSEL 8'h1c
`define ILFM_OFF_STARTSPD 8'h20
`define ILFM_OFF_STATUS 8'h24
`define ILFM_OFF_LINES 8'h28

`define ILFM_RST_LINE0 16'h003c
`define ILFM_RST_LINE1 16'h003d
`define ILFM_RST_LINE2 16'h0000
`define ILFM_RST_LINE3 16'h0001
`define ILFM_RST_LINE4 16'h0002
`define ILFM_RST_EXTDISP 16'h0000
`define ILFM_RST_REMOTE 16'h0000
`define ILFM_RST_STOPSEL 16'h270f
`define ILFM_RST_STARTSPD 16'h0000

`define ILFM_FC_LOW 16'h0000
`define ILFM_FC_MID 16'h0001
`define ILFM_FC_HIGH 16'h0002
`define ILFM_FC_SECOND 16'h0003
`define ILFM_FC_ANALOG4 16'h0004
`define ILFM_FC_JOG 16'h0005
`define ILFM_FC_HEAT 16'h0007
`define ILFM_FC_EXTRA 16'h0008
`define ILFM_FC_ENABLE 16'h000a
`define ILFM_FC_PUILK 16'h000c
`define ILFM_FC_PID 16'h000e
`define ILFM_FC_PUEXT 16'h0010
`define ILFM_FC_OUTSTOP 16'h0018
`define ILFM_FC_SELFHOLD 16'h0019
`define ILFM_FC_FWD 16'h003c
`define ILFM_FC_REV 16'h003d
`define ILFM_FC_RESET 16'h003e
`define ILFM_FC_PIDDIR 16'h0040
`define ILFM_FC_PUNET 16'h0041
`define ILFM_FC_EXTNET 16'h0042
`define ILFM_FC_CMDSRC 16'h0043
`define ILFM_FC_PIDRST 16'h0048
`define ILFM_FC_NONE 16'h270f

`define ILFM_STOP_DEC_A 16'h270f
`define ILFM_STOP_DEC_B 16'h22b8
`define ILFM_COAST_MAX 16'h0064
`define ILFM_COAST_OFS 16'h03e8
`define ILFM_COAST_OFS_MAX 16'h044c

`endif

// ===== hw/ilfm_line_filter.sv
// Per-line stable-time filter for synchronised input lines
`timescale 1ns/1ps
`include "ilfm_consts.svh"
module ilfm_line_filter #(
  parameter int NLINES = `ILFM_NLINES,
  parameter int STABLE_CYC = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // Lines
  input wire logic [NLINES-1:0] lineSync,
  output logic [NLINES-1:0] lineFilt
);
  localparam int CW = (STABLE_CYC > 1) ? $clog2(STABLE_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYC - 1);

  genvar l;
  generate
    for (l = 0; l < NLINES; l++) begin : g_line
      logic [CW-1:0] cntQ;
      // Level must stay put for the full count, so bounce never passes
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          cntQ <= '0;
          lineFilt[l] <= 1'b0;
        end else if (ce) begin
          if (lineSync[l] == lineFilt[l]) begin
            cntQ <= '0;
          end else if (cntQ == LAST) begin
            cntQ <= '0;
            lineFilt[l] <= lineSync[l];
          end else begin
            cntQ <= cntQ + CW'(1);
          end
        end
      end
    end
  endgenerate
endmodule

// ===== hw/ilfm_pkg.sv
// Types shared by the input line function mapper
package ilfm_pkg;

  typedef logic [15:0] ilfm_code_t;

  typedef enum {
    FN_LOW, FN_MID, FN_HIGH, FN_SECOND, FN_ANALOG4, FN_JOG, FN_HEAT, FN_EXTRA,
    FN_ENABLE, FN_PUILK, FN_PID, FN_PUEXT, FN_OUTSTOP, FN_SELFHOLD, FN_FWD,
    FN_REV, FN_RESET, FN_PIDDIR, FN_PUNET, FN_EXTNET, FN_CMDSRC, FN_PIDRST,
    FN_COUNT
  } ilfm_fn_t;

  typedef enum {
    ST_IDLE, ST_RUN, ST_HOLD, ST_DECEL, ST_COAST
  } ilfm_stop_state_t;

endpackage

// ===== hw/ilfm_stop_ctrl.sv
// Stop selection sequencer: decelerate, delayed coast, overrides and restart
`timescale 1ns/1ps
`include "ilfm_consts.svh"
module ilfm_stop_ctrl
  import ilfm_pkg::*;
#(
  parameter int SEC_CYC = `ILFM_SEC_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // Commands
  input wire logic runCmd,
  input wire logic panelStop,
  input wire logic commErrStop,
  input wire logic jogMode,
  input wire logic preexciteCmd,
  input wire logic preexciteBusy,
  input wire logic shutoff,
  input wire logic motorStopped,
  input wire logic [15:0] stopSel,
  // State
  output logic outputRun,
  output logic decelStop,
  output logic coasting,
  output logic restartPulse
);
  localparam int CW = (SEC_CYC > 1) ? $clog2(SEC_CYC) : 1;
  localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYC - 1);

  ilfm_stop_state_t stQ, stD;
  logic [CW-1:0] cycQ;
  logic [15:0] secQ;
  logic [15:0] coastSec;
  logic override;
  logic decelMode;
  logic preexDecel;

  assign override = panelStop | commErrStop | jogMode;
  assign decelMode = (stopSel == `ILFM_STOP_DEC_A) || (stopSel == `ILFM_STOP_DEC_B)
                     || override;
  assign preexDecel = preexciteCmd & preexciteBusy;
  assign coastSec = (stopSel >= `ILFM_COAST_OFS) ? stopSel - `ILFM_COAST_OFS : stopSel;

  always_comb begin
    stD = stQ;
    case (stQ)
      ST_IDLE: begin
        if (runCmd && !shutoff) stD = ST_RUN;
      end
      ST_RUN: begin
        if (shutoff) stD = ST_COAST;
        else if (!runCmd) stD = (decelMode || preexDecel) ? ST_DECEL : ST_HOLD;
      end
      ST_HOLD: begin
        // Speed command is still followed until the delay ends
        if (shutoff) stD = ST_COAST;
        else if (runCmd) stD = ST_RUN;
        else if (override || preexDecel) stD = ST_DECEL;
        else if (secQ == 16'h0000) stD = ST_COAST;
      end
      ST_DECEL: begin
        if (shutoff) stD = ST_COAST;
        else if (runCmd) stD = ST_RUN;
        else if (motorStopped) stD = ST_IDLE;
      end
      ST_COAST: begin
        if (runCmd && !shutoff) stD = ST_RUN;
        else if (preexDecel && !shutoff) stD = ST_DECEL;
        else if (motorStopped) stD = ST_IDLE;
      end
      default: stD = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stQ <= ST_IDLE;
      outputRun <= 1'b0;
      decelStop <= 1'b0;
      coasting <= 1'b0;
      restartPulse <= 1'b0;
    end else if (ce) begin
      stQ <= stD;
      outputRun <= (stD == ST_RUN) || (stD == ST_HOLD) || (stD == ST_DECEL);
      decelStop <= (stD == ST_DECEL);
      coasting <= (stD == ST_COAST);
      restartPulse <= (stQ != ST_RUN) && (stD == ST_RUN);
    end
  end

  // Delay timer counts whole seconds while holding
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cycQ <= '0;
      secQ <= 16'h0000;
    end else if (ce) begin
      if (stQ != ST_HOLD) begin
        cycQ <= '0;
        secQ <= coastSec;
      end else if (cycQ == SEC_LAST) begin
        cycQ <= '0;
        if (secQ != 16'h0000) secQ <= secQ - 16'h0001;
      end else begin
        cycQ <= cycQ + CW'(1);
      end
    end
  end
endmodule

// ===== hw/ilfm_top.sv
// Input line function mapper top: APB registers, line sync, mapping, stop control
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "ilfm_consts.svh"
module ilfm_top
  import ilfm_pkg::*;
#(
  parameter int FAST_CYC = `ILFM_FAST_CYC,
  parameter int SLOW_CYC = `ILFM_SLOW_CYC,
  parameter int SEC_CYC = `ILFM_SEC_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input line pins
  input wire logic [`ILFM_NLINES-1:0] lineIn,
  // Drive status, same clock
  input wire logic panelStop,
  input wire logic commErrStop,
  input wire logic preexciteCmd,
  input wire logic preexciteBusy,
  input wire logic motorStopped,
  // Functions
  output logic [FN_COUNT-1:0] funcActive,
  output logic [3:0] speedSelect,
  output logic [2:0] remoteSetting,
  // Run control
  output logic outputRun,
  output logic decelStop,
  output logic coasting,
  output logic restartFromStart,
  output logic [15:0] startSpeed
);
  // Line count follows the pin count
  localparam int NL = `ILFM_NLINES;
  localparam int NF = FN_COUNT;

  // Function codes in funcActive bit order
  localparam ilfm_code_t FN_CODE [NF] = '{
    `ILFM_FC_LOW, `ILFM_FC_MID, `ILFM_FC_HIGH, `ILFM_FC_SECOND,
    `ILFM_FC_ANALOG4, `ILFM_FC_JOG, `ILFM_FC_HEAT, `ILFM_FC_EXTRA,
    `ILFM_FC_ENABLE, `ILFM_FC_PUILK, `ILFM_FC_PID, `ILFM_FC_PUEXT,
    `ILFM_FC_OUTSTOP, `ILFM_FC_SELFHOLD, `ILFM_FC_FWD, `ILFM_FC_REV,
    `ILFM_FC_RESET, `ILFM_FC_PIDDIR, `ILFM_FC_PUNET, `ILFM_FC_EXTNET,
    `ILFM_FC_CMDSRC, `ILFM_FC_PIDRST
  };

  // Function each line wakes up with
  localparam ilfm_code_t LINE_RST [NL] = '{
    `ILFM_RST_LINE0,
    `ILFM_RST_LINE1,
    `ILFM_RST_LINE2,
    `ILFM_RST_LINE3,
    `ILFM_RST_LINE4
  };

  ////////////////////////////////////////////////////////////////////////////
  // Validity checks

  function automatic logic codeOk(input int line, input ilfm_code_t code);
    logic ok;
    // Code 9999 leaves the line with no function
    ok = (code == `ILFM_FC_NONE);
    for (int f = 0; f < NF; f++) begin
      if (code == FN_CODE[f]) ok = 1'b1;
    end
    // Run codes are bound to their own lines
    if (code == `ILFM_FC_FWD && line != 0) ok = 1'b0;
    if (code == `ILFM_FC_REV && line != 1) ok = 1'b0;
    return ok;
  endfunction

  function automatic logic stopSelOk(input logic [15:0] v);
    logic ok;
    // Coast delay, delayed coast with offset, or decelerate
    ok = (v <= `ILFM_COAST_MAX);
    if (v >= `ILFM_COAST_OFS && v <= `ILFM_COAST_OFS_MAX) ok = 1'b1;
    if (v == `ILFM_STOP_DEC_A || v == `ILFM_STOP_DEC_B) ok = 1'b1;
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Selections and settings are all 16 bits wide
  ilfm_code_t lineSelQ [NL];
  logic [15:0] extDispQ;
  logic [15:0] remoteQ;
  logic [15:0] stopSelQ;
  logic [15:0] startSpdQ;
  logic [NL-1:0] fastLvl;
  logic [NL-1:0] slowLvl;
  logic [NF-1:0] funcQ;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Handshake, line index and configuration lock
  logic accPh;
  logic wrStb;
  logic isLine;
  logic [2:0] lineIdx;
  logic cfgOpen;
  logic upperZero;
  logic [31:0] rdData;
  logic errD;

  assign accPh = psel & penable;
  // Write lands on the edge the master sees pready, never on the wait cycle
  assign wrStb = accPh & pwrite & pready & ~pslverr;
  assign lineIdx = paddr[4:2];
  assign isLine = (paddr[7:5] == 3'b000) && (lineIdx < 3'(NL))
                  && (paddr[1:0] == 2'b00);
  assign cfgOpen = (extDispQ == 16'h0000);
  assign upperZero = (pwdata[31:16] == 16'h0000);

  // Mapped reads never fail; line and stop-select writes check range, width and lock, other setting writes width only
  always_comb begin
    rdData = 32'h0000_0000;
    errD = 1'b0;
    if (isLine) begin
      rdData = {16'h0000, lineSelQ[lineIdx]};
      if (pwrite) begin
        errD = !cfgOpen || !upperZero || !codeOk(int'(lineIdx), pwdata[15:0]);
      end
    end else begin
      case (paddr)
        `ILFM_OFF_EXTDISP: begin
          rdData = {16'h0000, extDispQ};
          errD = pwrite && !upperZero;
        end
        `ILFM_OFF_REMOTE: begin
          rdData = {16'h0000, remoteQ};
          errD = pwrite && !upperZero;
        end
        `ILFM_OFF_STOPSEL: begin
          rdData = {16'h0000, stopSelQ};
          errD = pwrite && (!cfgOpen || !upperZero || !stopSelOk(pwdata[15:0]));
        end
        `ILFM_OFF_STARTSPD: begin
          rdData = {16'h0000, startSpdQ};
          errD = pwrite && !upperZero;
        end
        // Status and line views are read only
        `ILFM_OFF_STATUS: begin
          rdData = {7'h00, coasting, decelStop, outputRun, funcQ};
          errD = pwrite;
        end
        `ILFM_OFF_LINES: begin
          rdData = {19'h0_0000, fastLvl, 3'b000, slowLvl};
          errD = pwrite;
        end
        // Unmapped or unaligned words answer with an error
        default: begin
          rdData = 32'h0000_0000;
          errD = 1'b1;
        end
      endcase
    end
  end

  // One wait state so that data and error leave flip-flops
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      // Answer on every second cycle of an access, so a master that lingers sees pready again
      if (accPh && !pready) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0000_0000 : rdData;
        pslverr <= errD;
      end else begin
        pready <= 1'b0;
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration storage

  // Refused writes leave the stored code alone
  genvar gl;
  generate
    for (gl = 0; gl < NL; gl++) begin : g_sel
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          lineSelQ[gl] <= LINE_RST[gl];
        end else if (ce && wrStb && isLine && lineIdx == 3'(gl)) begin
          lineSelQ[gl] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      extDispQ <= `ILFM_RST_EXTDISP;
      remoteQ <= `ILFM_RST_REMOTE;
      stopSelQ <= `ILFM_RST_STOPSEL;
      startSpdQ <= `ILFM_RST_STARTSPD;
      // Display word is never locked, or setup could not reopen
    end else if (ce && wrStb && !isLine) begin
      case (paddr)
        `ILFM_OFF_EXTDISP: extDispQ <= pwdata[15:0];
        `ILFM_OFF_REMOTE: remoteQ <= pwdata[15:0];
        `ILFM_OFF_STOPSEL: stopSelQ <= pwdata[15:0];
        `ILFM_OFF_STARTSPD: startSpdQ <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      startSpeed <= `ILFM_RST_STARTSPD;
    end else if (ce) begin
      // Offered to restarts out of coast
      startSpeed <= startSpdQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers and filters

  // Pins are asynchronous: two flops before any logic reads them
  logic [NL-1:0] syncAQ;
  logic [NL-1:0] syncBQ;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      syncAQ <= '0;
      syncBQ <= '0;
    end else if (ce) begin
      syncAQ <= lineIn;
      syncBQ <= syncAQ;
    end
  end

  // Two filter depths; each function picks the one its timing needs
  // Short depth serves only the enable and shutoff codes
  ilfm_line_filter #(
    .NLINES(NL),
    .STABLE_CYC(FAST_CYC)
  ) u_fast (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .lineSync(syncBQ),
    .lineFilt(fastLvl)
  );

  ilfm_line_filter #(
    .NLINES(NL),
    .STABLE_CYC(SLOW_CYC)
  ) u_slow (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .lineSync(syncBQ),
    .lineFilt(slowLvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Function mapping

  // Shared codes OR their lines; unassigned functions stay low
  logic [NF-1:0] fnHit;

  always_comb begin
    fnHit = '0;
    for (int f = 0; f < NF; f++) begin
      for (int l = 0; l < NL; l++) begin
        if (lineSelQ[l] == FN_CODE[f]) begin
          if (f == int'(FN_ENABLE) || f == int'(FN_OUTSTOP)) begin
            fnHit[f] = fnHit[f] | fastLvl[l];
          end else begin
            fnHit[f] = fnHit[f] | slowLvl[l];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      funcQ <= '0;
      funcActive <= '0;
      speedSelect <= 4'h0;
      remoteSetting <= 3'h0;
    end else if (ce) begin
      // Every function output leaves a flop
      funcQ <= fnHit;
      // Analog ch4 and heat trip sit at FN_ANALOG4 and FN_HEAT
      funcActive <= fnHit;
      if (remoteQ == 16'h0000) begin
        speedSelect <= {fnHit[FN_EXTRA], fnHit[FN_HIGH], fnHit[FN_MID],
                        fnHit[FN_LOW]};
        remoteSetting <= 3'h0;
      end else begin
        speedSelect <= {fnHit[FN_EXTRA], 3'b000};
        remoteSetting <= {fnHit[FN_HIGH], fnHit[FN_MID], fnHit[FN_LOW]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop control

  // Either run direction starts the sequencer
  logic runCmd;
  assign runCmd = funcQ[FN_FWD] | funcQ[FN_REV];

  // Panel and communication stops are already on this clock
  ilfm_stop_ctrl #(
    .SEC_CYC(SEC_CYC)
  ) u_stop (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ce(ce),
    .runCmd(runCmd),
    .panelStop(panelStop),
    .commErrStop(commErrStop),
    .jogMode(funcQ[FN_JOG]),
    .preexciteCmd(preexciteCmd),
    .preexciteBusy(preexciteBusy),
    .shutoff(funcQ[FN_OUTSTOP]),
    .motorStopped(motorStopped),
    .stopSel(stopSelQ),
    .outputRun(outputRun),
    .decelStop(decelStop),
    .coasting(coasting),
    .restartPulse(restartFromStart)
  );

endmodule
